// [rtl/option_reg_pkg.sv]
package option_reg_pkg;

	// bus map
	localparam logic [15:0] OPT_ADDR    = 16'h001f;
	localparam logic [15:0] STATUS_ADDR = 16'h0020;

	// option field positions
	localparam int WD_DIS_BIT  = 0;
	localparam int STOP_EN_BIT = 1;
	localparam int WPS_BIT     = 2;
	localparam int SSR_BIT     = 3;

	// status field positions
	localparam int ST_USED_BIT = 0;
	localparam int ST_STOP_BIT = 1;
	localparam int ST_RCV_BIT  = 2;

	localparam logic [7:0] OPT_RESET = 8'h00;

	// bus clocks per oscillator cycle
	localparam int         OSC_DIV   = 1;
	localparam int         DIV_W     = 4;
	localparam logic [3:0] DIV_LAST  = 4'(OSC_DIV - 1);

	// recovery delays, in oscillator cycles
	localparam int STOP_SHORT_OSC = 32;
	localparam int STOP_LONG_OSC  = 4096;
	localparam int STOP_CNT_W     = 13;

	// watchdog period, in oscillator cycles
	localparam int WDOG_SHORT_EXP = 13;
	localparam int WDOG_LONG_EXP  = 18;
	localparam int WDOG_TRIM      = 16;
	localparam int WDOG_SHORT_OSC = (2 ** WDOG_SHORT_EXP) - WDOG_TRIM;
	localparam int WDOG_LONG_OSC  = (2 ** WDOG_LONG_EXP) - WDOG_TRIM;
	localparam int WDOG_CNT_W     = 19;

	typedef enum logic [1:0]
	{
		PWR_RUN     = 2'b00,
		PWR_STOPPED = 2'b01,
		PWR_RECOVER = 2'b10
	} pwr_state_t;

endpackage

// [rtl/option_ctrl_if.sv]
`timescale 1ns/10ps
interface option_ctrl_if;
	logic tick;
	logic stop_start;
	logic stop_long;
	logic stop_done;
	logic wdog_run;
	logic wdog_period_sel;
	logic wdog_clear;
	logic wdog_expire;

	modport ctrl
	(
		output tick,
		output stop_start,
		output stop_long,
		output wdog_run,
		output wdog_period_sel,
		output wdog_clear,
		input  stop_done,
		input  wdog_expire
	);

	modport stop_side
	(
		input  tick,
		input  stop_start,
		input  stop_long,
		output stop_done
	);

	modport wdog_side
	(
		input  tick,
		input  wdog_run,
		input  wdog_period_sel,
		input  wdog_clear,
		output wdog_expire
	);
endinterface

// [rtl/stop_recovery_timer.sv]
`timescale 1ns/10ps
module stop_recovery_timer
	import option_reg_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	option_ctrl_if.stop_side  ctl
);

	typedef struct packed
	{
		logic [STOP_CNT_W-1:0] cnt;
		logic                  busy;
		logic                  done;
	} stop_state_t;

	localparam logic [STOP_CNT_W-1:0] SHORT_LOAD = STOP_CNT_W'(STOP_SHORT_OSC);
	localparam logic [STOP_CNT_W-1:0] LONG_LOAD  = STOP_CNT_W'(STOP_LONG_OSC);

	stop_state_t s_r;
	stop_state_t s_nxt;

	always_comb
	begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		if (ctl.stop_start)
		begin
			s_nxt.cnt  = ctl.stop_long ? LONG_LOAD : SHORT_LOAD;
			s_nxt.busy = 1'b1;
		end
		else if (s_r.busy && ctl.tick)
		begin
			if (s_r.cnt == STOP_CNT_W'(1))
			begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end
			s_nxt.cnt = s_r.cnt - STOP_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign ctl.stop_done = s_r.done;

endmodule // stop_recovery_timer

// [rtl/watchdog_timer.sv]
`timescale 1ns/10ps
module watchdog_timer
	import option_reg_pkg::*;
#(
	parameter int SHORT_OSC = WDOG_SHORT_OSC,
	parameter int LONG_OSC  = WDOG_LONG_OSC
)
(
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	option_ctrl_if.wdog_side  ctl
);

	typedef struct packed
	{
		logic [WDOG_CNT_W-1:0] cnt;
		logic                  expire;
	} wdog_state_t;

	localparam logic [WDOG_CNT_W-1:0] SHORT_LAST = WDOG_CNT_W'(SHORT_OSC - 1);
	localparam logic [WDOG_CNT_W-1:0] LONG_LAST  = WDOG_CNT_W'(LONG_OSC - 1);

	wdog_state_t s_r;
	wdog_state_t s_nxt;
	logic [WDOG_CNT_W-1:0] last;

	always_comb
	begin
		last         = ctl.wdog_period_sel ? SHORT_LAST : LONG_LAST;
		s_nxt        = s_r;
		s_nxt.expire = 1'b0;
		if (!ctl.wdog_run || ctl.wdog_clear)
			s_nxt.cnt = '0;
		else if (ctl.tick)
		begin
			if (s_r.cnt >= last)
			begin
				s_nxt.cnt    = '0;
				s_nxt.expire = 1'b1;
			end
			else
				s_nxt.cnt = s_r.cnt + WDOG_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign ctl.wdog_expire = s_r.expire;

endmodule // watchdog_timer

// [rtl/option_register.sv]
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module option_register
	import option_reg_pkg::*;
#(
	parameter int WDOG_SHORT_CYC = WDOG_SHORT_OSC,
	parameter int WDOG_LONG_CYC  = WDOG_LONG_OSC
)
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	output logic      [7:0]  rd_data_out,
	input  wire logic        stop_opcode_in,
	input  wire logic        wake_irq_in,
	input  wire logic        reset_pin_wake_in,
	input  wire logic        wdog_clear_in,
	output logic             short_stop_recovery_out,
	output logic             watchdog_period_select_out,
	output logic             stop_enable_out,
	output logic             watchdog_disable_out,
	output logic             illegal_opcode_out,
	output logic             stop_mode_out,
	output logic             recovering_out,
	output logic             stop_exit_out,
	output logic             wdog_reset_out
);

	typedef struct packed
	{
		logic [7:0]      opt;
		logic            used;
		logic [7:0]      rd;
		pwr_state_t      pwr;
		logic            stop_mode;
		logic            recovering;
		logic            stop_start;
		logic            stop_long;
		logic            stop_exit;
		logic            illegal;
		logic            wd_clear;
		logic [DIV_W-1:0] div;
		logic            tick;
		logic [1:0]      pin_sync;
	} main_state_t;

	localparam main_state_t MAIN_RESET = '{
		opt:        OPT_RESET,
		used:       1'b0,
		rd:         8'h00,
		pwr:        PWR_RUN,
		stop_mode:  1'b0,
		recovering: 1'b0,
		stop_start: 1'b0,
		stop_long:  1'b0,
		stop_exit:  1'b0,
		illegal:    1'b0,
		wd_clear:   1'b0,
		div:        '0,
		tick:       1'b0,
		pin_sync:   2'b00
	};

	main_state_t s_r;
	main_state_t s_nxt;
	logic        opt_hit;
	logic        status_hit;
	logic        pin_wake;
	logic [7:0]  status_word;

	option_ctrl_if ctl ();

	stop_recovery_timer u_stop_timer
	(
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.ctl        (ctl.stop_side)
	);

	watchdog_timer #(
		.SHORT_OSC (WDOG_SHORT_CYC),
		.LONG_OSC  (WDOG_LONG_CYC)
	) u_watchdog (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.ctl        (ctl.wdog_side)
	);

	always_comb
	begin
		opt_hit    = (addr_in == OPT_ADDR);
		status_hit = (addr_in == STATUS_ADDR);
		// only the second synchroniser stage is looked at
		pin_wake   = s_r.pin_sync[1];

		status_word                = 8'h00;
		status_word[ST_USED_BIT]   = s_r.used;
		status_word[ST_STOP_BIT]   = s_r.stop_mode;
		status_word[ST_RCV_BIT]    = s_r.recovering;

		s_nxt            = s_r;
		s_nxt.stop_start = 1'b0;
		s_nxt.stop_exit  = 1'b0;
		s_nxt.illegal    = 1'b0;
		s_nxt.wd_clear   = wdog_clear_in;
		s_nxt.pin_sync   = {s_r.pin_sync[0], reset_pin_wake_in};

		// oscillator-rate enable; one pulse every OSC_DIV bus clocks
		if (s_r.div == DIV_LAST)
		begin
			s_nxt.div  = '0;
			s_nxt.tick = 1'b1;
		end
		else
		begin
			s_nxt.div  = s_r.div + DIV_W'(1);
			s_nxt.tick = 1'b0;
		end

		// write-once latch: a late write leaves no trace at all
		if (wr_en_in && opt_hit && !s_r.used)
		begin
			s_nxt.opt  = wr_data_in;
			s_nxt.used = 1'b1;
		end

		// read data stands in the cycle after the strobe only
		s_nxt.rd = 8'h00;
		if (rd_en_in && opt_hit)
			s_nxt.rd = s_r.opt;
		else if (rd_en_in && status_hit)
			s_nxt.rd = status_word;

		case (s_r.pwr)
			PWR_RUN:
			begin
				if (stop_opcode_in)
				begin
					if (s_r.opt[STOP_EN_BIT])
					begin
						s_nxt.pwr       = PWR_STOPPED;
						s_nxt.stop_mode = 1'b1;
					end
					else
						s_nxt.illegal = 1'b1;
				end
			end
			PWR_STOPPED:
			begin
				// pin wake takes priority so it never gets the short delay
				if (pin_wake || wake_irq_in)
				begin
					s_nxt.pwr        = PWR_RECOVER;
					s_nxt.recovering = 1'b1;
					s_nxt.stop_start = 1'b1;
					s_nxt.stop_long  = pin_wake || !s_r.opt[SSR_BIT];
				end
			end
			PWR_RECOVER:
			begin
				if (ctl.stop_done)
				begin
					s_nxt.pwr        = PWR_RUN;
					s_nxt.stop_mode  = 1'b0;
					s_nxt.recovering = 1'b0;
					s_nxt.stop_exit  = 1'b1;
				end
			end
			default:
			begin
				s_nxt.pwr        = PWR_RUN;
				s_nxt.stop_mode  = 1'b0;
				s_nxt.recovering = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			s_r <= MAIN_RESET;
		else
			s_r <= s_nxt;
	end

	assign ctl.tick            = s_r.tick;
	assign ctl.stop_start      = s_r.stop_start;
	assign ctl.stop_long       = s_r.stop_long;
	assign ctl.wdog_run        = !s_r.opt[WD_DIS_BIT];
	assign ctl.wdog_period_sel = s_r.opt[WPS_BIT];
	assign ctl.wdog_clear      = s_r.wd_clear;

	assign rd_data_out                = s_r.rd;
	assign short_stop_recovery_out    = s_r.opt[SSR_BIT];
	assign watchdog_period_select_out = s_r.opt[WPS_BIT];
	assign stop_enable_out            = s_r.opt[STOP_EN_BIT];
	assign watchdog_disable_out       = s_r.opt[WD_DIS_BIT];
	assign illegal_opcode_out         = s_r.illegal;
	assign stop_mode_out              = s_r.stop_mode;
	assign recovering_out             = s_r.recovering;
	assign stop_exit_out              = s_r.stop_exit;
	// comes straight from the watchdog's own flop
	assign wdog_reset_out             = ctl.wdog_expire;

endmodule // option_register

// [dv/option_register_monitor.sv]
`timescale 1ns/10ps
module option_register_monitor
	import option_reg_pkg::*;
(
	input logic		clk_in,
	input logic		sys_rst_in,
	input logic [15:0]	addr_in,
	input logic [7:0]	wr_data_in,
	input logic		wr_en_in,
	input logic		rd_en_in,
	input logic [7:0]	rd_data_out,
	input logic		stop_opcode_in,
	input logic		reset_pin_wake_in,
	input logic		short_stop_recovery_out,
	input logic		watchdog_period_select_out,
	input logic		stop_enable_out,
	input logic		watchdog_disable_out,
	input logic		illegal_opcode_out,
	input logic		stop_mode_out,
	input logic		recovering_out,
	input logic		stop_exit_out,
	input logic		wdog_reset_out
);
	logic [3:0]	opt;
	logic		used_r;
	logic		pin_r;
	logic [12:0]	rec_r;
	assign opt = {short_stop_recovery_out, watchdog_period_select_out, stop_enable_out,
		watchdog_disable_out};
	// a pin wake forces the long delay, so it is remembered until the exit pulse
	always_ff @(posedge clk_in)
	begin
		used_r <= !sys_rst_in && (used_r || (wr_en_in && addr_in == OPT_ADDR));
		pin_r <= !sys_rst_in && !stop_exit_out && (pin_r || (stop_mode_out && reset_pin_wake_in));
		rec_r <= (recovering_out && !sys_rst_in) ? rec_r + 13'h1 : 13'h0;
	end
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	first_write_a: assert property (
		wr_en_in && addr_in == OPT_ADDR && !used_r |=> opt == $past(wr_data_in[3:0]))
		else $error("first write lost");
	late_write_a: assert property (used_r |=> $stable(opt))
		else $error("late write taken");
	reset_clear_a: assert property (disable iff (1'h0) sys_rst_in |=> opt == 4'h0)
		else $error("reset left options");
	read_back_a: assert property (
		rd_en_in && addr_in == OPT_ADDR |=> rd_data_out[3:0] == $past(opt))
		else $error("bad read data");
	stop_refused_a: assert property (
		stop_opcode_in && !stop_enable_out && !stop_mode_out |=> illegal_opcode_out)
		else $error("stop not refused");
	stop_entry_a: assert property (
		stop_opcode_in && stop_enable_out && !stop_mode_out |=> stop_mode_out)
		else $error("stop not entered");
	recovery_len_a: assert property (
		// recovering also covers the timer load and done cycles, two beyond the count
		stop_exit_out |-> rec_r == ((short_stop_recovery_out && !pin_r) ? 13'h22 : 13'h1002))
		else $error("bad recovery length");
	wdog_off_a: assert property (
		watchdog_disable_out && $past(watchdog_disable_out) |-> !wdog_reset_out)
		else $error("watchdog fired while off");
	cover property (stop_exit_out && pin_r);
	cover property (illegal_opcode_out);
	cover property (wdog_reset_out && watchdog_period_select_out);
endmodule // option_register_monitor

// [dv/option_register_test.sv]
`timescale 1ns/10ps
module option_register_test;
	import option_reg_pkg::*;
	localparam int SC = 20;
	localparam int LC = 40;
	// exit pulse trails the count by the wake register, the timer load and the done flag
	localparam int REC_LAT = 3;
	// pin wake passes two synchroniser flops first
	localparam int SYNC_LAT = 2;
	logic		clk_in = 1'h0;
	logic		sys_rst_in = 1'h1;
	logic [15:0]	addr_in = 16'h0;
	logic [7:0]	wr_data_in = 8'h0;
	logic		wr_en_in = 1'h0;
	logic		rd_en_in = 1'h0;
	logic		stop_opcode_in = 1'h0;
	logic		wake_irq_in = 1'h0;
	logic		reset_pin_wake_in = 1'h0;
	logic		wdog_clear_in = 1'h0;
	logic [7:0]	rd_data_out;
	logic		short_stop_recovery_out, watchdog_period_select_out, stop_enable_out;
	logic		watchdog_disable_out, illegal_opcode_out, stop_mode_out;
	logic		recovering_out, stop_exit_out, wdog_reset_out;
	wire [3:0]	opt = {short_stop_recovery_out, watchdog_period_select_out, stop_enable_out,
		watchdog_disable_out};
	int		n_mismatch = 0;
	int		num_checks = 0;
	int		n;
	always #20 clk_in = ~clk_in;
	option_register #(.WDOG_SHORT_CYC(SC), .WDOG_LONG_CYC(LC)) dut
	(
		.clk_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
		.stop_opcode_in, .wake_irq_in, .reset_pin_wake_in, .wdog_clear_in,
		.short_stop_recovery_out, .watchdog_period_select_out, .stop_enable_out,
		.watchdog_disable_out, .illegal_opcode_out, .stop_mode_out, .recovering_out,
		.stop_exit_out, .wdog_reset_out
	);
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'h1;
		@(posedge clk_in);
		wr_en_in <= 1'h0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'h1;
		@(posedge clk_in);
		rd_en_in <= 1'h0;
		#1 chk("read data", e, rd_data_out);
	endtask
	// wake source held for one cycle; count runs from the edge that samples the wake
	task automatic stop_run(logic pn, int e);
		@(posedge clk_in);
		stop_opcode_in <= 1'h1;
		@(posedge clk_in);
		stop_opcode_in <= 1'h0;
		wake_irq_in <= !pn;
		reset_pin_wake_in <= pn;
		@(posedge clk_in);
		wake_irq_in <= 1'h0;
		reset_pin_wake_in <= 1'h0;
		n = 1;
		#1;
		while (stop_exit_out !== 1'h1 && n < 5000)
		begin
			@(posedge clk_in);
			#1 n++;
		end
		chk("recovery cycles", e, n);
	endtask
	// measured from one expiry pulse to the next, so the start phase does not matter
	task automatic wgap(int p);
		n = 0;
		while (wdog_reset_out !== 1'h1 && n < 200)
		begin
			@(posedge clk_in);
			#1 n++;
		end
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1 n++;
		end while (wdog_reset_out !== 1'h1 && n < 200);
		chk("watchdog period", p, n);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		#1 chk("options", 0, opt);
		wgap(LC);
		rd(OPT_ADDR, 8'h00);
		wr(OPT_ADDR, 8'h0e);
		#1 chk("options", 4'he, opt);
		wr(OPT_ADDR, 8'hf1);
		rd(OPT_ADDR, 8'h0e);
		rd(16'h0021, 8'h00);
		rd(STATUS_ADDR, 8'h01);
		wgap(SC);
		// clears every eight cycles keep the short period from ever running out
		n = 0;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk_in);
			wdog_clear_in <= (i % 8 == 0);
			#1 if (wdog_reset_out !== 1'h0) n++;
		end
		chk("watchdog cleared", 0, n);
		stop_run(1'h0, STOP_SHORT_OSC + REC_LAT);
		stop_run(1'h1, STOP_LONG_OSC + REC_LAT + SYNC_LAT);
		@(posedge clk_in);
		sys_rst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		#1 chk("options", 0, opt);
		@(posedge clk_in);
		stop_opcode_in <= 1'h1;
		@(posedge clk_in);
		stop_opcode_in <= 1'h0;
		#1 chk("refused stop", 1, {stop_mode_out, illegal_opcode_out});
		wr(OPT_ADDR, 8'h03);
		rd(OPT_ADDR, 8'h03);
		n = 0;
		repeat (100)
		begin
			@(posedge clk_in);
			#1 if (wdog_reset_out !== 1'h0) n++;
		end
		chk("watchdog off", 0, n);
		stop_run(1'h0, STOP_LONG_OSC + REC_LAT);
		final_report;
	end
	initial
	begin
		#800000;
		n_mismatch++;
		final_report;
	end
endmodule // option_register_test
bind option_register option_register_monitor mon
(
	.clk_in, .sys_rst_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
	.stop_opcode_in, .reset_pin_wake_in, .short_stop_recovery_out,
	.watchdog_period_select_out, .stop_enable_out, .watchdog_disable_out,
	.illegal_opcode_out, .stop_mode_out, .recovering_out, .stop_exit_out, .wdog_reset_out
);
